// ===== logic/gom_top.sv
// Purpose: source selection, software levels and polarity for gpio2, gpio0 and mute pins
// Assumes: all flag and clock inputs are synchronous to clk
// Notes: register writes reach the pins two edges after the write strobe
`timescale 1ns/1ps
module gom_top
	import gom_pkg::*;
#(
	parameter logic [7:0] DIE_ID = 8'h5A // value is arbitrary
) (
	input wire logic clk, // core clock, 20 MHz
	input wire logic rst_n, // synchronous reset, active low
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	input wire logic [7:0] reg_addr, // register offset
	input wire logic [7:0] reg_wdata, // write data
	output logic [7:0] reg_rdata, // read data, one cycle after reg_rd
	output logic reg_rvalid, // read data valid pulse
	input wire logic [4:0] gpio0_source_select, // gpio0 source code
	input wire logic [4:0] mute_source_select, // mute pin source code
	input wire logic gpio2_dir_out, // gpio2 set as output
	input wire logic gpio0_dir_out, // gpio0 set as output
	input wire logic dsp_gpio2, // processor gpio2 output
	input wire logic dsp_gpio0, // processor gpio0 output
	input wire logic dsp_mute, // processor mute output
	input wire logic auto_mute_l, // left auto-mute
	input wire logic auto_mute_r, // right auto-mute
	input wire logic clock_error, // clock error
	input wire logic clock_changing, // clock changing
	input wire logic clock_missing, // clock missing
	input wire logic clock_halt, // clock halt detected
	input wire logic serial_audio_out, // serial audio data out
	input wire logic analog_mute_l_n, // left analog mute, active low
	input wire logic analog_mute_r_n, // right analog mute, active low
	input wire logic pll_lock, // pll locked
	input wire logic charge_pump_clk, // charge pump clock
	input wire logic uv_high, // soft_mute_pin above upper threshold
	input wire logic uv_low, // soft_mute_pin above lower threshold
	input wire logic pll_clk, // pll clock, sampled
	input wire logic osc_clk, // oscillator clock, sampled
	input wire logic imp_sense_l, // left impedance sense
	input wire logic imp_sense_r, // right impedance sense
	input wire logic internal_uvp_n, // supply undervoltage, active low
	input wire logic offset_cal_busy, // offset calibration running
	input wire logic dsp_boot_done, // processor boot done
	input wire logic cp_valid_n, // charge pump valid, active low
	output logic gpio2_o, // gpio2 level
	output logic gpio2_oe_n, // gpio2 drive enable, active low
	output logic gpio0_o, // gpio0 level
	output logic gpio0_oe_n, // gpio0 drive enable, active low
	output logic mute_o // mute pin level
);

	////////////////////////////////////////////////////////////////////////
	// register file

	gom_regs_type st_q;
	gom_regs_type st_d;

	function automatic logic [7:0] read_mux(input logic [7:0] addr, input gom_regs_type r);
		logic [7:0] v;
		case (addr)
			OFS_GPIO2_SRC: v = r.gpio2_src;
			OFS_LEVELS: v = r.levels;
			OFS_POLARITY: v = r.polarity;
			OFS_DIE_ID: v = DIE_ID;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	always_comb begin
		st_d = st_q;
		st_d.rvalid = reg_rd;
		if (reg_rd) begin
			st_d.rdata = read_mux(reg_addr, st_q);
		end
		// reserved bits are kept and read back; the die id ignores writes
		if (reg_wr) begin
			case (reg_addr)
				OFS_GPIO2_SRC: st_d.gpio2_src = reg_wdata;
				OFS_LEVELS: st_d.levels = reg_wdata;
				OFS_POLARITY: st_d.polarity = reg_wdata;
				default: st_d.gpio2_src = st_q.gpio2_src;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q.gpio2_src <= RST_GPIO2_SRC;
			st_q.levels <= RST_LEVELS;
			st_q.polarity <= RST_POLARITY;
			st_q.rdata <= 8'h00;
			st_q.rvalid <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign reg_rvalid = st_q.rvalid;

	////////////////////////////////////////////////////////////////////////
	// divided clocks

	logic pll_div4;
	logic osc_div4;

	gom_clk_div #(.DIVIDE(CLK_DIVIDE)) u_pll_div (
		.clk(clk),
		.rst_n(rst_n),
		.src_clk(pll_clk),
		.div_out(pll_div4)
	);

	gom_clk_div #(.DIVIDE(CLK_DIVIDE)) u_osc_div (
		.clk(clk),
		.rst_n(rst_n),
		.src_clk(osc_clk),
		.div_out(osc_div4)
	);

	////////////////////////////////////////////////////////////////////////
	// source tables, one per pin, same code map

	logic [31:0] common_tbl;

	always_comb begin
		common_tbl = 32'h0000_0000;
		common_tbl[CODE_AMUTE_BOTH] = auto_mute_l & auto_mute_r;
		common_tbl[CODE_AMUTE_L] = auto_mute_l;
		common_tbl[CODE_CLK_INVALID] = clock_error | clock_changing | clock_missing;
		common_tbl[CODE_SDATA] = serial_audio_out;
		common_tbl[CODE_AMUTE_ANA_L] = analog_mute_l_n;
		common_tbl[CODE_AMUTE_ANA_R] = analog_mute_r_n;
		common_tbl[CODE_PLL_LOCK] = pll_lock;
		common_tbl[CODE_CP_CLK] = charge_pump_clk;
		common_tbl[CODE_UV_HIGH] = uv_high;
		common_tbl[CODE_UV_LOW] = uv_low;
		common_tbl[CODE_PLL_DIV4] = pll_div4;
		common_tbl[CODE_OSC_DIV4] = osc_div4;
		common_tbl[CODE_IMP_L] = imp_sense_l;
		common_tbl[CODE_IMP_R] = imp_sense_r;
		common_tbl[CODE_INT_UVP] = internal_uvp_n;
		common_tbl[CODE_OFFSET_CAL] = offset_cal_busy;
		common_tbl[CODE_CLK_ERR] = clock_error;
		common_tbl[CODE_CLK_CHG] = clock_changing;
		common_tbl[CODE_CLK_MISS] = clock_missing;
		common_tbl[CODE_CLK_HALT] = clock_halt;
		common_tbl[CODE_BOOT_DONE] = dsp_boot_done;
		common_tbl[CODE_CP_VALID_N] = cp_valid_n;
	end

	// the per-pin entries sit at codes 01 and 02 only
	function automatic logic [31:0] pin_table(input logic [31:0] base, input logic dsp, input logic level);
		logic [31:0] t;
		t = base;
		t[CODE_OFF] = 1'b0;
		t[CODE_DSP] = dsp;
		t[CODE_LEVEL] = level;
		return t;
	endfunction

	logic [31:0] gpio2_tbl;
	logic [31:0] gpio0_tbl;
	logic [31:0] mute_tbl;

	assign gpio2_tbl = pin_table(common_tbl, dsp_gpio2, st_q.levels[BIT_GPIO2]);
	assign gpio0_tbl = pin_table(common_tbl, dsp_gpio0, st_q.levels[BIT_GPIO0]);
	assign mute_tbl = pin_table(common_tbl, dsp_mute, st_q.levels[BIT_MUTE]);

	////////////////////////////////////////////////////////////////////////
	// pin stages

	gom_pin_out u_gpio2 (
		.clk(clk),
		.rst_n(rst_n),
		.sel(st_q.gpio2_src[SEL_MSB:0]),
		.table_in(gpio2_tbl),
		.invert(st_q.polarity[BIT_GPIO2]),
		.dir_out(gpio2_dir_out),
		.pin_o(gpio2_o),
		.pin_oe_n(gpio2_oe_n)
	);

	gom_pin_out u_gpio0 (
		.clk(clk),
		.rst_n(rst_n),
		.sel(gpio0_source_select),
		.table_in(gpio0_tbl),
		.invert(st_q.polarity[BIT_GPIO0]),
		.dir_out(gpio0_dir_out),
		.pin_o(gpio0_o),
		.pin_oe_n(gpio0_oe_n)
	);

	// the mute pin has no direction control, it is always driven
	gom_pin_out u_mute (
		.clk(clk),
		.rst_n(rst_n),
		.sel(mute_source_select),
		.table_in(mute_tbl),
		.invert(st_q.polarity[BIT_MUTE]),
		.dir_out(1'b1),
		.pin_o(mute_o),
		.pin_oe_n()
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_g2_plain(logic [4:0] code);
		st_q.gpio2_src[SEL_MSB:0] == code && !st_q.polarity[BIT_GPIO2];
	endsequence

	sequence s_write(logic [7:0] ofs);
		reg_wr && reg_addr == ofs;
	endsequence

	sequence s_g0_plain(logic [4:0] code);
		gpio0_source_select == code && !st_q.polarity[BIT_GPIO0];
	endsequence

	sequence s_mu_plain(logic [4:0] code);
		mute_source_select == code && !st_q.polarity[BIT_MUTE];
	endsequence

	AST_SEL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		s_write(OFS_GPIO2_SRC) |=> st_q.gpio2_src == $past(reg_wdata))
		else $error("gpio2 selector write not stored");

	AST_DIR_GATE: assert property (@(posedge clk) disable iff (!rst_n)
		!gpio2_dir_out |=> gpio2_oe_n)
		else $error("gpio2 driven while not an output");

	AST_OFF_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_OFF) |=> !gpio2_o)
		else $error("code off does not hold gpio2 low");

	AST_LEVEL_PATH: assert property (@(posedge clk) disable iff (!rst_n)
		s_write(OFS_LEVELS) ##1 s_g2_plain(CODE_LEVEL) |=> gpio2_o == $past(reg_wdata[BIT_GPIO2], 2))
		else $error("gpio2 level bit not routed two cycles after write");

	AST_AMUTE_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_AMUTE_BOTH) ##0 !(auto_mute_l && auto_mute_r) |=> !gpio2_o)
		else $error("both-channel auto-mute flag high with one channel active");

	AST_CLK_INVALID: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_CLK_INVALID) |=> gpio2_o == $past(clock_error | clock_changing | clock_missing))
		else $error("clock invalid flag wrong");

	AST_CAL_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_OFFSET_CAL) ##0 offset_cal_busy |=> gpio2_o)
		else $error("offset calibration flag dropped during calibration");

	AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.gpio2_src[SEL_MSB:0] == 5'h05 |=> gpio2_o == $past(st_q.polarity[BIT_GPIO2]))
		else $error("unassigned code does not drive zero");

	AST_INVERT: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.polarity[BIT_GPIO2] && st_q.gpio2_src[SEL_MSB:0] == CODE_OFF |=> gpio2_o)
		else $error("gpio2 inversion not applied");

	AST_DIE_ID: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == OFS_DIE_ID |=> reg_rvalid && reg_rdata == DIE_ID)
		else $error("die identifier read wrong");

	AST_DIE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		s_write(OFS_DIE_ID) ##[1:2] (reg_rd && reg_addr == OFS_DIE_ID) |=> reg_rdata == DIE_ID)
		else $error("die identifier changed by a write");

	AST_DIR_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
		gpio2_dir_out |=> !gpio2_oe_n)
		else $error("gpio2 not driven while an output");

	AST_G0_DIR: assert property (@(posedge clk) disable iff (!rst_n)
		gpio0_dir_out |=> !gpio0_oe_n)
		else $error("gpio0 not driven while an output");

	AST_DSP_ROUTE: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_DSP) |=> gpio2_o == $past(dsp_gpio2))
		else $error("processor gpio2 output not routed");

	AST_AMUTE_L: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_AMUTE_L) |=> gpio2_o == $past(auto_mute_l))
		else $error("left auto-mute flag not routed");

	AST_SDATA: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_SDATA) |=> gpio2_o == $past(serial_audio_out))
		else $error("serial data not routed");

	AST_ANA_MUTE_L: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_AMUTE_ANA_L) |=> gpio2_o == $past(analog_mute_l_n))
		else $error("left analog mute flag not routed");

	AST_ANA_MUTE_R: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_AMUTE_ANA_R) |=> gpio2_o == $past(analog_mute_r_n))
		else $error("right analog mute flag not routed");

	AST_CP_CLK: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_CP_CLK) |=> gpio2_o == $past(charge_pump_clk))
		else $error("charge pump clock not routed");

	AST_UV_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_UV_HIGH) |=> gpio2_o == $past(uv_high))
		else $error("upper undervoltage flag not routed");

	AST_UV_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_UV_LOW) |=> gpio2_o == $past(uv_low))
		else $error("lower undervoltage flag not routed");

	AST_PLL_DIV: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_PLL_DIV4) |=> gpio2_o == $past(pll_div4))
		else $error("divided pll clock not routed");

	AST_G0_OSC_DIV: assert property (@(posedge clk) disable iff (!rst_n)
		s_g0_plain(CODE_OSC_DIV4) |=> gpio0_o == $past(osc_div4))
		else $error("divided oscillator clock not routed to gpio0");

	AST_IMP_L: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_IMP_L) |=> gpio2_o == $past(imp_sense_l))
		else $error("left impedance flag not routed");

	AST_IMP_R: assert property (@(posedge clk) disable iff (!rst_n)
		s_g2_plain(CODE_IMP_R) |=> gpio2_o == $past(imp_sense_r))
		else $error("right impedance flag not routed");

	AST_G0_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
		s_g0_plain(CODE_LEVEL) |=> gpio0_o == $past(st_q.levels[BIT_GPIO0]))
		else $error("gpio0 level bit not routed");

	AST_MUTE_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
		s_mu_plain(CODE_LEVEL) |=> mute_o == $past(st_q.levels[BIT_MUTE]))
		else $error("mute level bit not routed");

	AST_G0_INVERT: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.polarity[BIT_GPIO0] && gpio0_source_select == CODE_OFF |=> gpio0_o)
		else $error("gpio0 inversion not applied");

	AST_MUTE_INVERT: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.polarity[BIT_MUTE] && mute_source_select == CODE_OFF |=> mute_o)
		else $error("mute inversion not applied");

	AST_RESET_STATE: assert property (@(posedge clk)
		!rst_n |=> st_q.gpio2_src == 8'h00 && st_q.levels == 8'h00 && st_q.polarity == 8'h00
			&& !gpio2_o && !gpio0_o && !mute_o)
		else $error("state not cleared by reset");

endmodule

// ===== logic/gom_pkg.sv
// Purpose: constants and state types for the general-purpose output routing block
// Assumes: 8-bit register port, one core clock, synchronous active-low reset
// Notes: source codes are shared by every routed pin
package gom_pkg;

	localparam logic [7:0] OFS_GPIO2_SRC = 8'h55;
	localparam logic [7:0] OFS_LEVELS = 8'h56;
	localparam logic [7:0] OFS_POLARITY = 8'h57;
	localparam logic [7:0] OFS_DIE_ID = 8'h58;

	localparam logic [7:0] RST_GPIO2_SRC = 8'h00;
	localparam logic [7:0] RST_LEVELS = 8'h00;
	localparam logic [7:0] RST_POLARITY = 8'h00;

	localparam int SEL_MSB = 4;
	localparam int BIT_GPIO2 = 5;
	localparam int BIT_MUTE = 4;
	localparam int BIT_GPIO0 = 3;

	localparam logic [4:0] CODE_OFF = 5'h00;
	localparam logic [4:0] CODE_DSP = 5'h01;
	localparam logic [4:0] CODE_LEVEL = 5'h02;
	localparam logic [4:0] CODE_AMUTE_BOTH = 5'h03;
	localparam logic [4:0] CODE_AMUTE_L = 5'h04;
	localparam logic [4:0] CODE_CLK_INVALID = 5'h06;
	localparam logic [4:0] CODE_SDATA = 5'h07;
	localparam logic [4:0] CODE_AMUTE_ANA_L = 5'h08;
	localparam logic [4:0] CODE_AMUTE_ANA_R = 5'h09;
	localparam logic [4:0] CODE_PLL_LOCK = 5'h0A;
	localparam logic [4:0] CODE_CP_CLK = 5'h0B;
	localparam logic [4:0] CODE_UV_HIGH = 5'h0E;
	localparam logic [4:0] CODE_UV_LOW = 5'h0F;
	localparam logic [4:0] CODE_PLL_DIV4 = 5'h10;
	localparam logic [4:0] CODE_OSC_DIV4 = 5'h11;
	localparam logic [4:0] CODE_IMP_L = 5'h12;
	localparam logic [4:0] CODE_IMP_R = 5'h13;
	localparam logic [4:0] CODE_INT_UVP = 5'h14;
	localparam logic [4:0] CODE_OFFSET_CAL = 5'h15;
	localparam logic [4:0] CODE_CLK_ERR = 5'h16;
	localparam logic [4:0] CODE_CLK_CHG = 5'h17;
	localparam logic [4:0] CODE_CLK_MISS = 5'h18;
	localparam logic [4:0] CODE_CLK_HALT = 5'h19;
	localparam logic [4:0] CODE_BOOT_DONE = 5'h1A;
	localparam logic [4:0] CODE_CP_VALID_N = 5'h1B;

	localparam int CLK_DIVIDE = 4;

	typedef struct packed {
		logic [7:0] gpio2_src;
		logic [7:0] levels;
		logic [7:0] polarity;
		logic [7:0] rdata;
		logic rvalid;
	} gom_regs_type;

	typedef struct packed {
		logic level;
		logic oe_n;
	} gom_pin_type;

	typedef struct packed {
		logic prev;
		logic [7:0] count;
		logic out;
	} gom_div_type;

endpackage

// ===== logic/gom_clk_div.sv
// Purpose: divide a sampled clock-like input by an even ratio
// Assumes: input is synchronous and slower than half the core clock
// Notes: counts rising edges of the sampled level
`timescale 1ns/1ps
module gom_clk_div
	import gom_pkg::*;
#(
	parameter int DIVIDE = CLK_DIVIDE
) (
	input wire logic clk, // core clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic src_clk, // sampled clock to divide
	output logic div_out // divided clock
);

	gom_div_type st_q;
	gom_div_type st_d;

	// output toggles every DIVIDE/2 rising edges, so its period is DIVIDE input periods
	always_comb begin
		st_d = st_q;
		st_d.prev = src_clk;
		if (src_clk && !st_q.prev) begin
			if (st_q.count == 8'(DIVIDE / 2 - 1)) begin
				st_d.count = 8'h00;
				st_d.out = !st_q.out;
			end else begin
				st_d.count = st_q.count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign div_out = st_q.out;

endmodule

// ===== logic/gom_pin_out.sv
// Purpose: registered output stage of one routed pin
// Assumes: source table already holds every code's signal
// Notes: output enable is low while the pin is driven
`timescale 1ns/1ps
module gom_pin_out
	import gom_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [4:0] sel, // source code
	input wire logic [31:0] table_in, // one signal per code
	input wire logic invert, // polarity control
	input wire logic dir_out, // pin set as output
	output logic pin_o, // pin level
	output logic pin_oe_n // pin drive enable, active low
);

	gom_pin_type st_q;
	gom_pin_type st_d;

	always_comb begin
		st_d.level = table_in[sel] ^ invert;
		st_d.oe_n = !dir_out;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= '{level: 1'b0, oe_n: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	assign pin_o = st_q.level;
	assign pin_oe_n = st_q.oe_n;

endmodule

// ===== testbench/gom_board.sv
// Purpose: board-side model that reads the routed gpio pins
// Assumes: no pull resistor on either trace
// Notes: a released trace shows the inverse of its last driven level so a stale level never passes for a drive
`timescale 1ns/1ps
module gom_board
	import gom_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic gpio2_o, // gpio2 level from device
	input wire logic gpio2_oe_n, // gpio2 drive enable, active low
	input wire logic gpio0_o, // gpio0 level from device
	input wire logic gpio0_oe_n, // gpio0 drive enable, active low
	output logic gpio2_wire, // level on gpio2 trace
	output logic gpio0_wire // level on gpio0 trace
);
	logic last2 = 1'b0;
	logic last0 = 1'b0;
	always @(posedge clk) begin
		if (!gpio2_oe_n) begin
			last2 <= gpio2_o;
		end
		if (!gpio0_oe_n) begin
			last0 <= gpio0_o;
		end
	end
	assign gpio2_wire = gpio2_oe_n ? ~last2 : gpio2_o;
	assign gpio0_wire = gpio0_oe_n ? ~last0 : gpio0_o;
endmodule

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the gpio output routing block
// Assumes: bench drives on falling edges, design samples on rising edges
// Notes: a write reaches the pins two edges after its strobe, a flag change one edge
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top
	import gom_pkg::*;
();
	localparam logic [7:0] TB_DIE_ID = 8'h3C; // value is arbitrary
	logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, lev, pol;
	logic [4:0] sel0 = 5'h00, selm = 5'h00, c2;
	logic dir2 = 1'b0, dir0 = 1'b0, pllc = 1'b0, oscc = 1'b0, p2, p0;
	logic [2:0] dsp = 3'h0;
	logic [18:0] f = 19'h00000;
	logic reg_rvalid, gpio2_o, gpio2_oe_n, gpio0_o, gpio0_oe_n, mute_o, gpio2_wire, gpio0_wire;
	logic [31:0] seed = 32'h4463AF63;
	int mismatches = 0, checks = 0, n2, n0;
	always #25 clk = ~clk;
	gom_top #(.DIE_ID(TB_DIE_ID)) dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.gpio0_source_select(sel0), .mute_source_select(selm), .gpio2_dir_out(dir2),
		.gpio0_dir_out(dir0), .dsp_gpio2(dsp[0]), .dsp_gpio0(dsp[1]), .dsp_mute(dsp[2]),
		.auto_mute_l(f[0]), .auto_mute_r(f[1]), .clock_error(f[2]), .clock_changing(f[3]),
		.clock_missing(f[4]), .clock_halt(f[5]), .serial_audio_out(f[6]), .analog_mute_l_n(f[7]),
		.analog_mute_r_n(f[8]), .pll_lock(f[9]), .charge_pump_clk(f[10]), .uv_high(f[11]),
		.uv_low(f[12]), .pll_clk(pllc), .osc_clk(oscc), .imp_sense_l(f[13]), .imp_sense_r(f[14]),
		.internal_uvp_n(f[15]), .offset_cal_busy(f[16]), .dsp_boot_done(f[17]), .cp_valid_n(f[18]),
		.gpio2_o(gpio2_o), .gpio2_oe_n(gpio2_oe_n), .gpio0_o(gpio0_o), .gpio0_oe_n(gpio0_oe_n),
		.mute_o(mute_o));
	gom_board board (.clk(clk), .gpio2_o(gpio2_o), .gpio2_oe_n(gpio2_oe_n), .gpio0_o(gpio0_o),
		.gpio0_oe_n(gpio0_oe_n), .gpio2_wire(gpio2_wire), .gpio0_wire(gpio0_wire));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// divider phase is not modelled, so random codes avoid it
	function automatic logic [4:0] nodiv(logic [4:0] c);
		return (c == 5'h10 || c == 5'h11) ? 5'h00 : c;
	endfunction
	function automatic logic exp_src(logic [4:0] c, logic lvl, logic dsp_bit);
		case (c)
			5'h01: return dsp_bit;
			5'h02: return lvl;
			5'h03: return f[0] & f[1];
			5'h04: return f[0];
			5'h06: return f[2] | f[3] | f[4];
			5'h07: return f[6];
			5'h08: return f[7];
			5'h09: return f[8];
			5'h0A: return f[9];
			5'h0B: return f[10];
			5'h0E: return f[11];
			5'h0F: return f[12];
			5'h12: return f[13];
			5'h13: return f[14];
			5'h14: return f[15];
			5'h15: return f[16];
			5'h16: return f[2];
			5'h17: return f[3];
			5'h18: return f[4];
			5'h19: return f[5];
			5'h1A: return f[17];
			5'h1B: return f[18];
			default: return 1'b0;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd_chk(string nm, logic [7:0] a, logic [7:0] e);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		`CHK(nm, e, reg_rdata)
		`CHK("rvalid", 1'b1, reg_rvalid)
	endtask
	task automatic reset_chk();
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		`CHK("gpio2 after reset", 2'b01, {gpio2_o, gpio2_oe_n})
		`CHK("gpio0 mute after reset", 3'b010, {gpio0_o, gpio0_oe_n, mute_o})
		for (int i = 0; i < 3; i++) begin
			rd_chk("reset value", 8'(OFS_GPIO2_SRC + i), 8'h00);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		reset_chk();
		for (int i = 0; i < 3; i++) begin
			seed = lfsr_next(seed);
			wr(8'(OFS_GPIO2_SRC + i), seed[7:0]);
			rd_chk("readback", 8'(OFS_GPIO2_SRC + i), seed[7:0]);
		end
		wr(OFS_DIE_ID, 8'hFF);
		rd_chk("die id", OFS_DIE_ID, TB_DIE_ID);
		wr(8'h59, 8'hA5);
		rd_chk("unmapped", 8'h59, 8'h00);
		rd_chk("unmapped low", 8'h54, 8'h00);
		// first 32 passes walk every code except 10 and 11 (sent as 00), the rest are random
		for (int i = 0; i < 96; i++) begin
			seed = lfsr_next(seed);
			c2 = nodiv((i < 32) ? 5'(i) : seed[4:0]);
			lev = seed[15:8];
			pol = seed[23:16];
			wr(OFS_GPIO2_SRC, {seed[31:29], c2});
			wr(OFS_LEVELS, lev);
			wr(OFS_POLARITY, pol);
			seed = lfsr_next(seed);
			f = seed[18:0];
			dsp = seed[21:19];
			dir2 = seed[22];
			dir0 = seed[23];
			sel0 = nodiv(seed[28:24]);
			selm = nodiv(seed[4:0] ^ seed[31:27]);
			@(negedge clk);
			`CHK("gpio2_o", exp_src(c2, lev[5], dsp[0]) ^ pol[5], gpio2_o)
			`CHK("gpio0_o", exp_src(sel0, lev[3], dsp[1]) ^ pol[3], gpio0_o)
			`CHK("mute_o", exp_src(selm, lev[4], dsp[2]) ^ pol[4], mute_o)
			`CHK("oe_n", {~dir2, ~dir0}, {gpio2_oe_n, gpio0_oe_n})
			if (dir2 === 1'b1) begin
				`CHK("gpio2 trace", exp_src(c2, lev[5], dsp[0]) ^ pol[5], gpio2_wire)
			end
			if (dir0 === 1'b1) begin
				`CHK("gpio0 trace", exp_src(sel0, lev[3], dsp[1]) ^ pol[3], gpio0_wire)
			end
		end
		reset_chk();
		wr(OFS_GPIO2_SRC, {3'h0, CODE_PLL_DIV4});
		sel0 = CODE_OSC_DIV4;
		n2 = 0;
		n0 = 0;
		repeat (2) @(negedge clk);
		for (int i = 0; i < 32; i++) begin
			p2 = gpio2_o;
			p0 = gpio0_o;
			pllc = ~pllc;
			oscc = ~oscc;
			@(negedge clk);
			n2 += int'(p2 !== gpio2_o);
			n0 += int'(p0 !== gpio0_o);
		end
		// 16 source rises in the window give 8 output toggles, one may fall at the edge
		`CHK("pll div4", 1'b1, n2 >= 7 && n2 <= 8)
		`CHK("osc div4", 1'b1, n0 >= 7 && n0 <= 8)
		close_out();
	end
endmodule
